// ==== uhsr_hub_ctrl.sv ====
`timescale 1ns/1ps
module uhsr_hub_ctrl
   import uhsr_pkg::*;
#(
   parameter int CHIRP_LEN = CHIRP_CYC,
   parameter int HS_WAIT_LEN = HS_WAIT_CYC,
   parameter int SUSP_LEN = SUSP_CYC,
   parameter int RESUME_LEN = RESUME_CYC
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic clk_en,
   input wire logic upstream_vbus_sense,
   input wire logic up_dp,
   input wire logic up_dm,
   output logic pullup_en,
   output logic up_drive_k,
   output logic hs_mode,
   output logic suspended,
   output logic ee_sclk,
   output logic ee_cs_n,
   output logic ee_mosi,
   input wire logic ee_miso,
   output uhsr_ids_s ids,
   output logic [6:0] dev_addr,
   output logic [7:0] cfg_value,
   output logic multi_tt,
   output logic hub_ready,
   input uhsr_req_s req,
   input wire logic tok_valid,
   input wire logic [7:0] tok_pid,
   input wire logic [6:0] tok_addr,
   output logic tok_hit,
   input wire logic [N_PORT-1:0] dn_wake,
   input uhsr_speed_t [N_PORT-1:0] dn_speed,
   output uhsr_route_t [N_PORT-1:0] dn_route,
   input wire logic in_valid,
   output logic in_ready,
   input uhsr_word_s in_word,
   output logic out_valid,
   input wire logic out_ready,
   output uhsr_dn_s out_data
);
   localparam logic [CNT_W-1:0] T_SE0 = CNT_W'(SE0_RST_CYC - 1);
   localparam logic [CNT_W-1:0] T_CHIRP = CNT_W'(CHIRP_LEN - 1);
   localparam logic [CNT_W-1:0] T_HSW = CNT_W'(HS_WAIT_LEN - 1);
   localparam logic [CNT_W-1:0] T_SUSP = CNT_W'(SUSP_LEN - 1);
   localparam logic [CNT_W-1:0] T_RES = CNT_W'(RESUME_LEN - 1);
   localparam logic [1:0] T_DIV = 2'(SPI_HALF_CYC - 1);
   localparam logic [6:0] B_HDR = 7'(EE_HDR_BITS);
   localparam logic [6:0] B_LAST = 7'(EE_HDR_BITS + EE_ID_BITS - 1);
   localparam logic [1:0] N_PAIRS = 2'(CHIRP_PAIRS);

   typedef struct packed {
      uhsr_link_e link;
      logic vb_s1;
      logic vb_s2;
      logic [1:0] ln_s1;
      logic [1:0] ln_s2;
      logic [1:0] ln_p;
      logic mi_s1;
      logic mi_s2;
      logic [CNT_W-1:0] cnt;
      logic [1:0] pairs;
      logic sclk;
      logic [1:0] div;
      logic [6:0] bits;
      logic [15:0] cmd;
      logic [47:0] sh;
      logic cs_n;
      uhsr_ids_s ids;
      logic [6:0] addr;
      logic [7:0] cfg;
      logic multi;
      logic busy;
      logic [N_PORT-1:0] mask;
      logic xl;
      uhsr_route_t [N_PORT-1:0] route;
      logic tok_hit;
      logic pull;
      logic up_k;
      logic hs;
      logic susp;
   } uhsr_st_s;

   uhsr_st_s st_r, st_nxt;
   logic cfgd, acc, push, buf_rdy, bus_rst, hs_pair, up_state, xl;
   logic [N_PORT-1:0] m, ttm;
   uhsr_dn_s bdata;

   function automatic uhsr_route_t rt_of(input uhsr_speed_t s,
                                         input logic hs);
      if (s == SPD_NONE) begin
         rt_of = RT_OFF;
      end else if (!hs) begin
         rt_of = RT_REP;
      end else if (s == SPD_HIGH) begin
         rt_of = RT_REP;
      end else begin
         rt_of = RT_TT;
      end
   endfunction

   function automatic logic tok_ok(input logic [7:0] p);
      tok_ok = (p[3:0] == ~p[7:4]) && (p[1:0] == PID_TOK_TYPE);
   endfunction

   function automatic logic [N_PORT-1:0] onehot(input logic [1:0] p);
      onehot = '0;
      onehot[p] = 1'b1;
   endfunction

   assign cfgd = st_r.cfg != CFG_NONE;
   // unconfigured traffic is swallowed so the engine never hangs
   assign in_ready = buf_rdy || !cfgd;
   assign acc = in_valid && in_ready;
   assign push = acc && cfgd;
   assign bus_rst = (st_r.ln_s2 == LN_SE0) && (st_r.cnt >= T_SE0);
   assign hs_pair = (st_r.ln_p == LN_K) && (st_r.ln_s2 == LN_J);
   assign up_state = (st_r.link == LK_FS) || (st_r.link == LK_HS);
   assign bdata.word = in_word;
   assign bdata.mask = m;
   assign bdata.xlate = xl;

   always_comb begin
      ttm = '0;
      for (int i = 0; i < N_PORT; i++) begin
         ttm[i] = st_r.route[i] == RT_TT;
      end
      m = st_r.mask;
      xl = st_r.xl;
      if (!st_r.busy) begin
         if (st_r.route[in_word.port] == RT_TT) begin
            m = st_r.multi ? onehot(in_word.port) : ttm;
            xl = 1'b1;
         end else if (st_r.route[in_word.port] == RT_REP) begin
            m = onehot(in_word.port);
            xl = 1'b0;
         end else begin
            m = '0;
            xl = 1'b0;
         end
      end
   end

   always_comb begin
      st_nxt = st_r;
      st_nxt.vb_s1 = upstream_vbus_sense;
      st_nxt.vb_s2 = st_r.vb_s1;
      st_nxt.ln_s1 = {up_dp, up_dm};
      st_nxt.ln_s2 = st_r.ln_s1;
      st_nxt.ln_p = st_r.ln_s2;
      st_nxt.mi_s1 = ee_miso;
      st_nxt.mi_s2 = st_r.mi_s1;
      st_nxt.tok_hit = tok_valid && tok_ok(tok_pid) &&
                       (tok_addr == st_r.addr);
      // line-condition timer, restarted on any line change outside LK_CHIRP, LK_HS_WAIT and LK_RESUME
      if (st_r.ln_s2 != st_r.ln_p) begin
         st_nxt.cnt = '0;
      end else if (st_r.cnt != '1) begin
         st_nxt.cnt = st_r.cnt + 1'b1;
      end
      case (st_r.link)
         LK_LOAD: begin
            if (st_r.cs_n) begin
               st_nxt.cs_n = 1'b0;
            end else if (st_r.div != T_DIV) begin
               st_nxt.div = st_r.div + 1'b1;
            end else begin
               st_nxt.div = '0;
               st_nxt.sclk = !st_r.sclk;
               // sample late in the high phase: sync delay is covered
               if (st_r.sclk) begin
                  st_nxt.cmd = {st_r.cmd[14:0], 1'b0};
                  st_nxt.bits = st_r.bits + 1'b1;
                  if (st_r.bits >= B_HDR) begin
                     st_nxt.sh = {st_r.sh[46:0], st_r.mi_s2};
                  end
                  if (st_r.bits == B_LAST) begin
                     st_nxt.cs_n = 1'b1;
                     st_nxt.ids = {st_r.sh[46:0], st_r.mi_s2};
                     st_nxt.link = LK_WAIT_VBUS;
                  end
               end
            end
         end
         LK_WAIT_VBUS: begin
            if (st_r.vb_s2) begin
               st_nxt.link = LK_ATTACH;
            end
         end
         LK_ATTACH, LK_FS, LK_HS: begin
            if (bus_rst) begin
               st_nxt.link = LK_CHIRP;
               st_nxt.cnt = '0;
               st_nxt.addr = '0;
               st_nxt.cfg = CFG_NONE;
               st_nxt.multi = 1'b0;
            end else if (st_r.link == LK_FS && st_r.ln_s2 == LN_J &&
                         st_r.cnt >= T_SUSP && !st_r.busy) begin
               st_nxt.link = LK_SUSP;
            end
         end
         LK_CHIRP: begin
            st_nxt.cnt = st_r.cnt + 1'b1;
            if (st_r.cnt == T_CHIRP) begin
               st_nxt.link = LK_HS_WAIT;
               st_nxt.cnt = '0;
               st_nxt.pairs = '0;
            end
         end
         LK_HS_WAIT: begin
            st_nxt.cnt = st_r.cnt + 1'b1;
            if (hs_pair) begin
               st_nxt.pairs = st_r.pairs + 1'b1;
            end
            if (hs_pair && st_r.pairs == N_PAIRS - 2'h1) begin
               st_nxt.link = LK_HS;
            end else if (st_r.cnt == T_HSW) begin
               st_nxt.link = LK_FS;
            end
         end
         LK_SUSP: begin
            if (bus_rst) begin
               st_nxt.link = LK_CHIRP;
               st_nxt.cnt = '0;
               st_nxt.addr = '0;
               st_nxt.cfg = CFG_NONE;
               st_nxt.multi = 1'b0;
            end else if (st_r.ln_s2 == LN_K) begin
               st_nxt.link = LK_FS;
            end else if (|dn_wake) begin
               st_nxt.link = LK_RESUME;
               st_nxt.cnt = '0;
            end
         end
         LK_RESUME: begin
            st_nxt.cnt = st_r.cnt + 1'b1;
            if (st_r.cnt == T_RES) begin
               st_nxt.link = LK_FS;
            end
         end
         default: begin
            st_nxt.link = LK_LOAD;
         end
      endcase
      if (req.valid && up_state && !bus_rst) begin
         case (req.code)
            REQ_SET_ADDR: begin
               if (req.value[6:0] != st_r.addr) begin
                  st_nxt.cfg = CFG_NONE;
                  st_nxt.multi = 1'b0;
               end
               st_nxt.addr = req.value[6:0];
            end
            REQ_SET_CFG: begin
               st_nxt.cfg = req.value;
               st_nxt.multi = 1'b0;
            end
            REQ_SET_IF: begin
               if (cfgd && st_r.link == LK_HS) begin
                  st_nxt.multi = req.value == ALT_MULTI_TT;
               end
            end
            default: begin
               st_nxt.multi = st_r.multi;
            end
         endcase
      end
      if (st_r.link != LK_LOAD && !st_r.vb_s2) begin
         st_nxt.link = LK_WAIT_VBUS;
         st_nxt.addr = '0;
         st_nxt.cfg = CFG_NONE;
         st_nxt.multi = 1'b0;
      end
      // routes follow port speed only between packets
      if (!st_r.busy) begin
         for (int i = 0; i < N_PORT; i++) begin
            st_nxt.route[i] = rt_of(dn_speed[i], st_r.link == LK_HS);
         end
      end
      if (push) begin
         st_nxt.busy = !in_word.last;
         st_nxt.mask = m;
         st_nxt.xl = xl;
      end else if (!cfgd) begin
         st_nxt.busy = 1'b0;
      end
      st_nxt.pull = st_r.vb_s2 && (st_nxt.link == LK_ATTACH ||
                    st_nxt.link == LK_CHIRP ||
                    st_nxt.link == LK_HS_WAIT ||
                    st_nxt.link == LK_FS ||
                    st_nxt.link == LK_SUSP ||
                    st_nxt.link == LK_RESUME);
      st_nxt.up_k = st_nxt.link == LK_CHIRP ||
                    st_nxt.link == LK_RESUME;
      st_nxt.hs = st_nxt.link == LK_HS;
      st_nxt.susp = st_nxt.link == LK_SUSP;
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         st_r <= '0;
         st_r.link <= LK_LOAD;
         st_r.cs_n <= 1'b1;
         st_r.cmd <= {EE_CMD_READ, EE_ADDR};
      end else if (clk_en) begin
         st_r <= st_nxt;
      end
   end

   // two entries so a receiver stall loses no word
   uhsr_buf2 #(
      .W($bits(uhsr_dn_s)),
      .DEPTH(2)
   ) u_buf (
      .mclk(mclk),
      .rst_n(rst_n),
      .clk_en(clk_en),
      .in_valid(push),
      .in_ready(buf_rdy),
      .in_data(bdata),
      .out_valid(out_valid),
      .out_ready(out_ready),
      .out_data(out_data)
   );

   assign pullup_en = st_r.pull;
   assign up_drive_k = st_r.up_k;
   assign hs_mode = st_r.hs;
   assign suspended = st_r.susp;
   assign ee_sclk = st_r.sclk;
   assign ee_cs_n = st_r.cs_n;
   assign ee_mosi = st_r.cmd[15];
   assign ids = st_r.ids;
   assign dev_addr = st_r.addr;
   assign cfg_value = st_r.cfg;
   assign multi_tt = st_r.multi;
   assign hub_ready = cfgd;
   assign tok_hit = st_r.tok_hit;
   assign dn_route = st_r.route;

   load_pull_a:
   assert property (@(posedge mclk) disable iff (!rst_n)
      st_r.link == LK_LOAD |-> !pullup_en)
      else $error("pull-up on before eeprom load");

   vbus_pull_a:
   assert property (@(posedge mclk) disable iff (!rst_n)
      clk_en && !st_r.vb_s2 |=> !pullup_en)
      else $error("pull-up on without vbus");

   hs_pull_a:
   assert property (@(posedge mclk) disable iff (!rst_n)
      hs_mode |-> !pullup_en && !up_drive_k)
      else $error("pull-up still on at high speed");

   chirp_len_a:
   assert property (@(posedge mclk) disable iff (!rst_n)
      $rose(st_r.link == LK_CHIRP) |-> up_drive_k [*8])
      else $error("chirp K dropped early");

   fs_fallback_a:
   assert property (@(posedge mclk) disable iff (!rst_n)
      clk_en && st_r.vb_s2 && st_r.link == LK_HS_WAIT &&
      st_r.cnt == T_HSW && !hs_pair |=> st_r.link == LK_FS && !hs_mode)
      else $error("no fall back to full speed");

   rst_clear_a:
   assert property (@(posedge mclk) disable iff (!rst_n)
      st_r.link == LK_CHIRP |-> cfg_value == 8'h00 && dev_addr == 7'h00)
      else $error("state kept across bus reset");

   addr_unconf_a:
   assert property (@(posedge mclk) disable iff (!rst_n)
      clk_en && req.valid && req.code == REQ_SET_ADDR && up_state &&
      req.value[6:0] != dev_addr |=> cfg_value == 8'h00 && !multi_tt)
      else $error("address change kept configuration");

   cfg_single_a:
   assert property (@(posedge mclk) disable iff (!rst_n)
      clk_en && req.valid && req.code == REQ_SET_CFG && up_state
      |=> !multi_tt)
      else $error("configuration did not pick single mode");

   cfg_gate_a:
   assert property (@(posedge mclk) disable iff (!rst_n)
      // watch the buffer output, not the gate itself
      clk_en && cfg_value == 8'h00 && !out_valid |=> !out_valid)
      else $error("traffic forwarded while unconfigured");

   hs_route_a:
   assert property (@(posedge mclk) disable iff (!rst_n)
      clk_en && !st_r.busy && st_r.link == LK_HS &&
      dn_speed[0] == SPD_HIGH |=> dn_route[0] == RT_REP)
      else $error("high speed device not on repeater");

   mask_hold_a:
   assert property (@(posedge mclk) disable iff (!rst_n)
      clk_en && st_r.busy |=> $stable(st_r.mask) && $stable(dn_route))
      else $error("routing changed inside a packet");
endmodule // uhsr_hub_ctrl

// ==== uhsr_pkg.sv ====
package uhsr_pkg;
   localparam int CLK_NS = 25;
   localparam int SE0_RST_NS = 2500;
   localparam int SE0_RST_CYC = (SE0_RST_NS + CLK_NS - 1) / CLK_NS;
   localparam int CHIRP_US = 1000;
   localparam int CHIRP_CYC = (CHIRP_US * 1000 + CLK_NS - 1) / CLK_NS;
   localparam int HS_WAIT_US = 2000;
   localparam int HS_WAIT_CYC = (HS_WAIT_US * 1000) / CLK_NS;
   localparam int SUSP_US = 3000;
   localparam int SUSP_CYC = (SUSP_US * 1000 + CLK_NS - 1) / CLK_NS;
   localparam int RESUME_US = 1000;
   localparam int RESUME_CYC = (RESUME_US * 1000 + CLK_NS - 1) / CLK_NS;
   localparam int CNT_W = 17;
   localparam int CHIRP_PAIRS = 3;
   localparam int SPI_HALF_CYC = 4;
   localparam logic [7:0] EE_CMD_READ = 8'h03;
   localparam logic [7:0] EE_ADDR = 8'h00;
   localparam int EE_HDR_BITS = 16;
   localparam int EE_ID_BITS = 48;
   localparam int N_PORT = 4;
   localparam logic [1:0] LN_SE0 = 2'h0;
   localparam logic [1:0] LN_J = 2'h2;
   localparam logic [1:0] LN_K = 2'h1;
   localparam logic [1:0] PID_TOK_TYPE = 2'h1;
   localparam logic [7:0] ALT_MULTI_TT = 8'h01;
   localparam logic [7:0] CFG_NONE = 8'h00;

   typedef logic [1:0] uhsr_speed_t;
   localparam uhsr_speed_t SPD_NONE = 2'h0;
   localparam uhsr_speed_t SPD_LOW = 2'h1;
   localparam uhsr_speed_t SPD_FULL = 2'h2;
   localparam uhsr_speed_t SPD_HIGH = 2'h3;

   typedef logic [1:0] uhsr_route_t;
   localparam uhsr_route_t RT_OFF = 2'h0;
   localparam uhsr_route_t RT_REP = 2'h1;
   localparam uhsr_route_t RT_TT = 2'h2;

   localparam logic [1:0] REQ_SET_ADDR = 2'h1;
   localparam logic [1:0] REQ_SET_CFG = 2'h2;
   localparam logic [1:0] REQ_SET_IF = 2'h3;

   typedef enum logic [8:0] {
      LK_LOAD = 9'h001,
      LK_WAIT_VBUS = 9'h002,
      LK_ATTACH = 9'h004,
      LK_CHIRP = 9'h008,
      LK_HS_WAIT = 9'h010,
      LK_FS = 9'h020,
      LK_HS = 9'h040,
      LK_SUSP = 9'h080,
      LK_RESUME = 9'h100
   } uhsr_link_e;

   typedef struct packed {
      logic valid;
      logic [1:0] code;
      logic [7:0] value;
   } uhsr_req_s;

   typedef struct packed {
      logic [7:0] data;
      logic last;
      logic [1:0] port;
   } uhsr_word_s;

   typedef struct packed {
      uhsr_word_s word;
      logic [N_PORT-1:0] mask;
      logic xlate;
   } uhsr_dn_s;

   typedef struct packed {
      logic [15:0] vid;
      logic [15:0] pid;
      logic [15:0] device_release_identifier;
   } uhsr_ids_s;
endpackage

// ==== uhsr_buf2.sv ====
`timescale 1ns/1ps
module uhsr_buf2 #(
   parameter int W = 16,
   parameter int DEPTH = 2
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic clk_en,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam logic [AW:0] FULL = (AW+1)'(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem;
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0] cnt;
   } uhsr_bst_s;

   uhsr_bst_s st_r, st_nxt;
   logic push, pop;

   function automatic logic [AW-1:0] step(input logic [AW-1:0] p);
      step = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
   endfunction

   assign in_ready = st_r.cnt != FULL;
   assign out_valid = st_r.cnt != '0;
   assign out_data = st_r.mem[st_r.rp];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always_comb begin
      st_nxt = st_r;
      if (push) begin
         st_nxt.mem[st_r.wp] = in_data;
         st_nxt.wp = step(st_r.wp);
      end
      if (pop) begin
         st_nxt.rp = step(st_r.rp);
      end
      if (push && !pop) begin
         st_nxt.cnt = st_r.cnt + 1'b1;
      end else if (pop && !push) begin
         st_nxt.cnt = st_r.cnt - 1'b1;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         st_r <= '0;
      end else if (clk_en) begin
         st_r <= st_nxt;
      end
   end
endmodule // uhsr_buf2

// ==== uhsr_ee_model.sv ====
`timescale 1ns/1ps
module uhsr_ee_model #(
   parameter logic [47:0] ID = 48'h0
) (
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic mosi,
   output logic miso,
   output logic [15:0] cmd
);
   int n = 0;
   initial miso = 1'b0;
   always @(negedge cs_n) begin
      n = 0;
      cmd = '0;
   end
   // opcode and address in msb first, then ids out msb first
   always @(posedge sclk) begin
      if (!cs_n) begin
         if (n < 16) cmd = {cmd[14:0], mosi};
         n = n + 1;
      end
   end
   // idle line flips so a stale bit never passes for data
   always @(negedge sclk or posedge cs_n) begin
      if (!cs_n && n >= 16 && n < 64) miso <= ID[63 - n];
      else miso <= ~miso;
   end
endmodule // uhsr_ee_model

// ==== uhsr_hub_ctrl_tb_top.sv ====
`timescale 1ns/1ps
module uhsr_hub_ctrl_tb_top
   import uhsr_pkg::*;
;
   localparam logic [47:0] ID = 48'h1a2b_3c4d_5e6f; // arbitrary value
   logic mclk = 0, rst_n = 0, upstream_vbus_sense = 0, ee_miso;
   logic pullup_en, up_drive_k, hs_mode, suspended, ee_sclk, ee_cs_n;
   logic ee_mosi, multi_tt, hub_ready, tok_hit, in_ready, out_valid;
   logic tok_valid = 0, in_valid = 0, out_ready = 0, stall = 0;
   logic [1:0] line = LN_J;
   logic [3:0] dn_wake = 0;
   logic [7:0] tok_pid = 0, cfg_value;
   logic [6:0] tok_addr = 0, dev_addr;
   logic [15:0] ee_cmd;
   uhsr_ids_s ids;
   uhsr_req_s req = '0;
   uhsr_word_s in_word = '0;
   uhsr_dn_s out_data;
   uhsr_speed_t [N_PORT-1:0] spd = '0;
   uhsr_route_t [N_PORT-1:0] dn_route;
   int failures = 0, cmp_count = 0;
   bit [31:0] seed = 63965;
   bit m_hs = 0, m_multi = 0, m_cfg = 0, pkt_last = 1;
   uhsr_dn_s eq[$];

   always #12.5 mclk = ~mclk;

   // idle long enough to finish enumeration before the hub suspends
   uhsr_hub_ctrl #(.CHIRP_LEN(8), .HS_WAIT_LEN(40), .SUSP_LEN(300),
      .RESUME_LEN(10)) dut_u (.mclk(mclk), .rst_n(rst_n), .clk_en(1'b1),
      .upstream_vbus_sense(upstream_vbus_sense), .up_dp(line[1]),
      .up_dm(line[0]), .pullup_en(pullup_en), .up_drive_k(up_drive_k),
      .hs_mode(hs_mode), .suspended(suspended), .ee_sclk(ee_sclk),
      .ee_cs_n(ee_cs_n), .ee_mosi(ee_mosi), .ee_miso(ee_miso), .ids(ids),
      .dev_addr(dev_addr), .cfg_value(cfg_value), .multi_tt(multi_tt),
      .hub_ready(hub_ready), .req(req), .tok_valid(tok_valid),
      .tok_pid(tok_pid), .tok_addr(tok_addr), .tok_hit(tok_hit),
      .dn_wake(dn_wake), .dn_speed(spd), .dn_route(dn_route),
      .in_valid(in_valid), .in_ready(in_ready), .in_word(in_word),
      .out_valid(out_valid), .out_ready(out_ready), .out_data(out_data));

   uhsr_ee_model #(.ID(ID)) ee_u (.sclk(ee_sclk), .cs_n(ee_cs_n),
      .mosi(ee_mosi), .miso(ee_miso), .cmd(ee_cmd));

   function automatic bit [31:0] xs;
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   function automatic uhsr_route_t rt(uhsr_speed_t s);
      if (s == SPD_NONE) return RT_OFF;
      if (!m_hs || s == SPD_HIGH) return RT_REP;
      return RT_TT;
   endfunction

   function automatic uhsr_dn_s expw(uhsr_word_s w);
      uhsr_dn_s d;
      d = '0;
      d.word = w;
      if (rt(spd[w.port]) == RT_TT) begin
         d.xlate = 1'b1;
         if (m_multi) d.mask[w.port] = 1'b1;
         else for (int p = 0; p < N_PORT; p++)
            d.mask[p] = (rt(spd[p]) == RT_TT);
      end else if (rt(spd[w.port]) == RT_REP) d.mask[w.port] = 1'b1;
      return d;
   endfunction

   task automatic summarize;
      $display("checks %0d failures %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         failures++;
         $display("wrong value t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
   endtask

   task automatic waitv(ref logic s, input logic v, input int lim);
      for (int i = 0; i < lim && s !== v; i++) @(posedge mclk);
      if (s !== v) begin
         failures++;
         summarize();
      end
   endtask

   task automatic do_req(input logic [1:0] c, input logic [7:0] v);
      @(posedge mclk) req <= '{1'b1, c, v};
      @(posedge mclk) req.valid <= 1'b0;
      tick(2);
   endtask

   task automatic tok(input logic [7:0] pid, input logic [6:0] a,
         input logic exp);
      @(posedge mclk) tok_valid <= 1'b1;
      tok_pid <= pid;
      tok_addr <= a;
      @(posedge mclk) tok_valid <= 1'b0;
      #1 check(tok_hit, exp);
   endtask

   task automatic push(input logic [1:0] p);
      uhsr_word_s w;
      int k;
      w.data = 8'(xs());
      w.last = pkt_last;
      w.port = p;
      k = 0;
      @(posedge mclk) in_valid <= 1'b1;
      in_word <= w;
      do begin
         @(posedge mclk);
         k++;
      end while (in_ready !== 1'b1 && k < 50);
      if (in_ready !== 1'b1) begin
         failures++;
         summarize();
      end
      if (m_cfg) eq.push_back(expw(w));
      in_valid <= 1'b0;
   endtask

   task automatic bus_reset(input bit chirp);
      line <= LN_SE0;
      waitv(up_drive_k, 1'b1, 150);
      waitv(up_drive_k, 1'b0, 20);
      if (chirp) repeat (3) begin
         line <= LN_K;
         tick(4);
         line <= LN_J;
         tick(4);
      end else line <= LN_J;
      tick(50);
      m_hs = chirp;
      m_cfg = 0;
      m_multi = 0;
      check(hs_mode, chirp);
      check(pullup_en, !chirp);
      check({dev_addr, cfg_value, multi_tt}, 0);
   endtask

   // a word leaving the buffer must match the oldest expected one
   always @(posedge mclk) begin
      if (rst_n && out_valid && out_ready) begin
         if (eq.size() != 0) check(out_data, eq.pop_front());
         else check(out_valid, 1'b0);
      end
      out_ready <= !stall && (xs() % 4 != 0);
   end

   initial begin
      tick(10);
      rst_n <= 1'b1;
      waitv(ee_cs_n, 1'b0, 5);
      waitv(ee_cs_n, 1'b1, 700);
      tick(20);
      check(ids, ID);
      check(ee_cmd, {EE_CMD_READ, EE_ADDR});
      check(pullup_en, 1'b0);
      upstream_vbus_sense <= 1'b1;
      waitv(pullup_en, 1'b1, 10);
      bus_reset(0);
      for (int p = 0; p < N_PORT; p++) spd[p] <= 2'(1 + xs() % 3);
      push(2'h0);
      do_req(REQ_SET_ADDR, 8'h05);
      do_req(REQ_SET_CFG, 8'h01);
      do_req(REQ_SET_IF, ALT_MULTI_TT);
      m_cfg = 1;
      check({dev_addr, cfg_value, hub_ready, multi_tt},
         {7'h05, 8'h01, 2'b10});
      for (int p = 0; p < N_PORT; p++) check(dn_route[p], RT_REP);
      for (int p = 0; p < N_PORT; p++) push(2'(p));
      tok(8'he1, 7'h05, 1'b1);
      tok(8'hc3, 7'h05, 1'b0);
      tok(8'hf1, 7'h05, 1'b0);
      tok(8'h69, 7'h40 | 7'(xs()), 1'b0);
      do_req(REQ_SET_ADDR, 8'h06);
      m_cfg = 0;
      check({dev_addr, cfg_value}, {7'h06, 8'h00});
      do_req(REQ_SET_CFG, 8'h01);
      m_cfg = 1;
      waitv(suspended, 1'b1, 400);
      dn_wake <= 4'h4;
      waitv(up_drive_k, 1'b1, 10);
      dn_wake <= 4'h0;
      waitv(suspended, 1'b0, 40);
      // host resume: K on the idle line leaves suspend
      waitv(suspended, 1'b1, 400);
      line <= LN_K;
      waitv(suspended, 1'b0, 6);
      check(hs_mode, 1'b0);
      bus_reset(1);
      spd <= {SPD_FULL, SPD_FULL, SPD_LOW, SPD_HIGH};
      do_req(REQ_SET_ADDR, 8'h07);
      do_req(REQ_SET_CFG, 8'h01);
      m_cfg = 1;
      check(multi_tt, 1'b0);
      for (int p = 0; p < N_PORT; p++) check(dn_route[p], rt(spd[p]));
      do_req(REQ_SET_IF, ALT_MULTI_TT);
      m_multi = 1;
      check(multi_tt, 1'b1);
      for (int p = 0; p < N_PORT; p++) push(2'(p));
      // two-word packet keeps its route until the last word
      pkt_last = 0;
      push(2'h1);
      pkt_last = 1;
      push(2'h1);
      do_req(REQ_SET_IF, 8'h00);
      m_multi = 0;
      check(multi_tt, 1'b0);
      for (int p = 0; p < N_PORT; p++) push(2'(p));
      tick(20);
      stall <= 1'b1;
      tick(2);
      push(2'h1);
      push(2'h3);
      fork
         begin
            tick(6);
            check(in_ready, 1'b0);
            stall <= 1'b0;
         end
         push(2'h2);
      join
      tick(30);
      check(eq.size(), 0);
      upstream_vbus_sense <= 1'b0;
      tick(6);
      check({pullup_en, dev_addr, cfg_value}, 0);
      summarize();
   end
endmodule // uhsr_hub_ctrl_tb_top
